// File: src/adc_cfg_pkg.sv
// Notes on behaviour
// - select pin held high keeps the serial port disabled; all serial traffic ignored.
// - port disabled: clock/format pin high selects twos complement, low offset binary.
// - offset binary: 000 at negative full scale, 800 at zero, fff at positive.
// - twos complement: 800 at negative full scale, 000 at zero, 7ff at positive.
// - out-of-range flag high only for samples beyond range, aligned with its word.
// - decode port setup 0x00-0x02, commit register 0xff, converter registers 0x08 and 0x2a.
// - converter register writes act only after the commit bit is set.
// - commit bit 0 copies every master register into its active copy at once.
// - overrange register 0x2a resets to 0x01; clearing bit 0 disables the flag.
// - soft reset reloads defaults into critical registers; data path keeps its contents.
// - after power-up the port shifts msb first, changed only via port setup.
// - grade register reports a two-bit speed grade; other bits read zero.
package adc_cfg_pkg;
   localparam int ADDR_W   = 13;
   localparam int SAMPLE_W = 12;

   // register offsets
   localparam logic [12:0] OFS_PORT_SETUP = 13'h0000;
   localparam logic [12:0] OFS_PART_ID    = 13'h0001;
   localparam logic [12:0] OFS_GRADE      = 13'h0002;
   localparam logic [12:0] OFS_POWER_MODE = 13'h0008;
   localparam logic [12:0] OFS_OVERRANGE  = 13'h002a;
   localparam logic [12:0] OFS_SHADOW_UPD = 13'h00ff;

   // reset values
   localparam logic [7:0] RST_PORT_SETUP = 8'h18;
   localparam logic [7:0] RST_POWER_MODE = 8'h00;
   localparam logic [7:0] RST_OVERRANGE  = 8'h01;
   localparam logic [7:0] RST_SHADOW_UPD = 8'h00;

   // field positions and writable masks
   localparam int PS_LSB_HI   = 6;
   localparam int PS_LSB_LO   = 1;
   localparam int PS_SRST_HI  = 5;
   localparam int PS_SRST_LO  = 2;
   localparam int PM_PIN_ACT  = 5;
   localparam int GRADE_LO    = 3;
   localparam int COMMIT_BIT  = 0;
   localparam int OVR_EN_BIT  = 0;
   localparam int INSTR_RD    = 15;
   localparam logic [7:0] MASK_POWER_MODE = 8'h27;
   localparam logic [7:0] MASK_OVERRANGE  = 8'h01;

   // internal power field codes
   localparam logic [2:0] PWR_FULL_DOWN = 3'h1;
   localparam logic [2:0] PWR_STANDBY   = 3'h2;

   // serial frame bit counts
   localparam logic [4:0] INSTR_LAST = 5'h0f;
   localparam logic [4:0] DATA_LAST  = 5'h17;

   // output codes and full-scale limits of the signed sample
   localparam logic [11:0] CODE_MSB = 12'h800;
   localparam logic [11:0] OB_MIN   = 12'h000;
   localparam logic [11:0] OB_MAX   = 12'hfff;
   localparam logic signed [13:0] SAMPLE_POS_FS = 14'h07ff;
   localparam logic signed [13:0] SAMPLE_NEG_FS = 14'h3800;

   typedef enum logic [1:0] {
      PH_INSTR = 2'b00,
      PH_DATA  = 2'b01,
      PH_DONE  = 2'b10
   } link_phase_type;

   typedef enum logic [1:0] {
      PWR_ON  = 2'b00,
      PWR_OFF = 2'b01,
      PWR_SBY = 2'b10
   } power_state_type;
endpackage : adc_cfg_pkg

// File: src/serial_link_engine.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_engine #(
   parameter logic [7:0] PART_ID = 8'h5c,
   parameter logic [1:0] GRADE   = 2'b00
) (
   // link clock and frame
   input  wire logic        sclk_in,
   input  wire logic        rst_in,
   input  wire logic        port_select_low_in,
   input  wire logic        sdio_in,
   output var  logic        sdio_out,
   output var  logic        sdio_oe_out,
   // settings and readback from the bank
   input  wire logic        lsb_first_in,
   input  wire logic [7:0]  port_setup_in,
   input  wire logic [7:0]  power_mode_in,
   input  wire logic [7:0]  overrange_in,
   input  wire logic [7:0]  shadow_update_in,
   // write hand-off
   output var  logic        wr_toggle_out,
   output var  logic [12:0] wr_addr_out,
   output var  logic [7:0]  wr_data_out
);
   typedef struct packed {
      adc_cfg_pkg::link_phase_type phase;
      logic [4:0]                  cnt;
      logic [22:0]                 sh;
      logic                        rd;
      logic [7:0]                  rbyte;
   } frame_type;

   typedef struct packed {
      logic        toggle;
      logic [12:0] addr;
      logic [7:0]  data;
   } hold_type;

   frame_type frame_ff;
   frame_type nxt_frame;
   hold_type  hold_ff;
   hold_type  nxt_hold;
   logic      frame_rst;

   // select high holds the frame logic in reset, so traffic is ignored
   assign frame_rst = rst_in | port_select_low_in;

   function automatic logic [7:0] read_byte(input logic [12:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a == adc_cfg_pkg::OFS_PORT_SETUP) begin
         r = port_setup_in;
      end else if (a == adc_cfg_pkg::OFS_PART_ID) begin
         r = PART_ID;
      end else if (a == adc_cfg_pkg::OFS_GRADE) begin
         r = 8'({GRADE, 3'h0});
      end else if (a == adc_cfg_pkg::OFS_POWER_MODE) begin
         r = power_mode_in;
      end else if (a == adc_cfg_pkg::OFS_OVERRANGE) begin
         r = overrange_in;
      end else if (a == adc_cfg_pkg::OFS_SHADOW_UPD) begin
         r = shadow_update_in;
      end
      return r;
   endfunction : read_byte

   always_comb begin
      logic [23:0] full;
      logic [15:0] ins;
      logic [7:0]  dat;
      full      = {frame_ff.sh, sdio_in};
      ins       = full[15:0];
      dat       = full[7:0];
      nxt_frame = frame_ff;
      nxt_hold  = hold_ff;
      if (lsb_first_in) begin
         ins = {<<{full[15:0]}};
         dat = {<<{full[7:0]}};
      end
      case (frame_ff.phase)
         adc_cfg_pkg::PH_INSTR: begin
            nxt_frame.sh  = full[22:0];
            nxt_frame.cnt = frame_ff.cnt + 5'h01;
            if (frame_ff.cnt == adc_cfg_pkg::INSTR_LAST) begin
               nxt_frame.rd    = ins[adc_cfg_pkg::INSTR_RD];
               nxt_frame.rbyte = read_byte(ins[12:0]);
               nxt_hold.addr   = ins[12:0];
               nxt_frame.phase = adc_cfg_pkg::PH_DATA;
            end
         end
         adc_cfg_pkg::PH_DATA: begin
            nxt_frame.sh  = full[22:0];
            nxt_frame.cnt = frame_ff.cnt + 5'h01;
            if (frame_ff.cnt == adc_cfg_pkg::DATA_LAST) begin
               nxt_frame.phase = adc_cfg_pkg::PH_DONE;
               if (!frame_ff.rd) begin
                  nxt_hold.data   = dat;
                  nxt_hold.toggle = ~hold_ff.toggle;
               end
            end
         end
         default: begin
            // one byte per frame; further bits are ignored
            nxt_frame.phase = adc_cfg_pkg::PH_DONE;
         end
      endcase
   end

   always_ff @(posedge sclk_in or posedge frame_rst) begin
      if (frame_rst) begin
         frame_ff <= '0;
      end else begin
         frame_ff <= nxt_frame;
      end
   end

   // address stays put until the next frame and data until the next write, long after the bank samples them
   always_ff @(posedge sclk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_ff <= '0;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   // readback changes on the falling edge so the controller samples on the rising one
   always_ff @(negedge sclk_in or posedge frame_rst) begin
      if (frame_rst) begin
         sdio_out    <= 1'b0;
         sdio_oe_out <= 1'b0;
      end else begin
         sdio_oe_out <= frame_ff.rd && (frame_ff.phase == adc_cfg_pkg::PH_DATA);
         if (lsb_first_in) begin
            sdio_out <= frame_ff.rbyte[frame_ff.cnt[2:0]];
         end else begin
            sdio_out <= frame_ff.rbyte[3'h7 - frame_ff.cnt[2:0]];
         end
      end
   end

   assign wr_toggle_out = hold_ff.toggle;
   assign wr_addr_out   = hold_ff.addr;
   assign wr_data_out   = hold_ff.data;
endmodule : serial_link_engine
`default_nettype wire

// File: src/adc_config_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank #(
   // arbitrary identifier and grade values
   parameter logic [7:0] PART_ID = 8'h5c,
   parameter logic [1:0] GRADE   = 2'b00
) (
   // clock, reset, enable
   input  wire logic                          clock_in,
   input  wire logic                          rst_in,
   input  wire logic                          ce_in,
   // serial port pins
   input  wire logic                          serial_clock_format_pin_in,
   input  wire logic                          port_select_low_in,
   input  wire logic                          sdio_in,
   output var  logic                          sdio_out,
   output var  logic                          sdio_oe_out,
   // power-down pin
   input  wire logic                          power_down_pin_in,
   // converter core sample
   input  wire logic signed [13:0]            sample_value_in,
   // output word and status
   output var  logic [11:0]                   data_out,
   output var  logic                          overrange_out,
   output var  logic                          twos_coding_out,
   output var  logic                          port_active_out,
   output var  adc_cfg_pkg::power_state_type  power_state_out
);
   typedef struct packed {
      logic                         csb_s1;
      logic                         csb_s2;
      logic                         fmt_s1;
      logic                         fmt_s2;
      logic                         pd_s1;
      logic                         pd_s2;
      logic                         tog_s1;
      logic                         tog_s2;
      logic                         tog_s3;
      logic                         port_used;
      logic [7:0]                   port_setup;
      logic [7:0]                   pwr_master;
      logic [7:0]                   pwr_active;
      logic [7:0]                   ovr_master;
      logic [7:0]                   ovr_active;
      logic                         commit;
      logic                         twos;
      logic [11:0]                  data;
      logic                         over;
      adc_cfg_pkg::power_state_type pwr_state;
   } bank_state_type;

   bank_state_type bank_ff;
   bank_state_type nxt_bank;
   logic           wr_toggle;
   logic [12:0]    wr_addr;
   logic [7:0]     wr_data;

   serial_link_engine #(
      .PART_ID (PART_ID),
      .GRADE   (GRADE)
   ) link_u (
      .sclk_in            (serial_clock_format_pin_in),
      .rst_in             (rst_in),
      .port_select_low_in (port_select_low_in),
      .sdio_in            (sdio_in),
      .sdio_out           (sdio_out),
      .sdio_oe_out        (sdio_oe_out),
      .lsb_first_in       (bank_ff.port_setup[adc_cfg_pkg::PS_LSB_HI]),
      .port_setup_in      (bank_ff.port_setup),
      .power_mode_in      (bank_ff.pwr_master),
      .overrange_in       (bank_ff.ovr_master),
      .shadow_update_in   ({7'h00, bank_ff.commit}),
      .wr_toggle_out      (wr_toggle),
      .wr_addr_out        (wr_addr),
      .wr_data_out        (wr_data)
   );

   always_comb begin
      logic        lsb;
      logic        srst;
      logic [11:0] code;
      logic        beyond;
      lsb      = 1'b0;
      srst     = 1'b0;
      code     = 12'h000;
      beyond   = 1'b0;
      nxt_bank = bank_ff;
      if (ce_in) begin
         nxt_bank.csb_s1 = port_select_low_in;
         nxt_bank.csb_s2 = bank_ff.csb_s1;
         nxt_bank.fmt_s1 = serial_clock_format_pin_in;
         nxt_bank.fmt_s2 = bank_ff.fmt_s1;
         nxt_bank.pd_s1  = power_down_pin_in;
         nxt_bank.pd_s2  = bank_ff.pd_s1;
         nxt_bank.tog_s1 = wr_toggle;
         nxt_bank.tog_s2 = bank_ff.tog_s1;
         nxt_bank.tog_s3 = bank_ff.tog_s2;

         // a select that never falls means the port is strapped off
         if (!bank_ff.csb_s2) begin
            nxt_bank.port_used = 1'b1;
         end

         // copy then drop the commit bit; a new commit write below still wins
         nxt_bank.commit = 1'b0;
         if (bank_ff.commit) begin
            nxt_bank.pwr_active = bank_ff.pwr_master;
            nxt_bank.ovr_active = bank_ff.ovr_master;
         end

         if (bank_ff.tog_s2 != bank_ff.tog_s3) begin
            if (wr_addr == adc_cfg_pkg::OFS_PORT_SETUP) begin
               lsb  = wr_data[adc_cfg_pkg::PS_LSB_HI] | wr_data[adc_cfg_pkg::PS_LSB_LO];
               srst = wr_data[adc_cfg_pkg::PS_SRST_HI] | wr_data[adc_cfg_pkg::PS_SRST_LO];
               nxt_bank.port_setup = {1'b0, lsb, 1'b0, 2'b11, 1'b0, lsb, 1'b0};
               if (srst) begin
                  // soft reset self-clears by reloading defaults
                  nxt_bank.port_setup = adc_cfg_pkg::RST_PORT_SETUP;
                  nxt_bank.pwr_master = adc_cfg_pkg::RST_POWER_MODE;
                  nxt_bank.pwr_active = adc_cfg_pkg::RST_POWER_MODE;
                  nxt_bank.ovr_master = adc_cfg_pkg::RST_OVERRANGE;
                  nxt_bank.ovr_active = adc_cfg_pkg::RST_OVERRANGE;
                  nxt_bank.commit     = adc_cfg_pkg::RST_SHADOW_UPD[adc_cfg_pkg::COMMIT_BIT];
               end
            end else if (wr_addr == adc_cfg_pkg::OFS_POWER_MODE) begin
               // only the master changes here; it acts after commit
               nxt_bank.pwr_master = wr_data & adc_cfg_pkg::MASK_POWER_MODE;
            end else if (wr_addr == adc_cfg_pkg::OFS_OVERRANGE) begin
               nxt_bank.ovr_master = wr_data & adc_cfg_pkg::MASK_OVERRANGE;
            end else if (wr_addr == adc_cfg_pkg::OFS_SHADOW_UPD) begin
               nxt_bank.commit = wr_data[adc_cfg_pkg::COMMIT_BIT];
            end
            // identifier, grade and unmapped writes are dropped
         end

         // coding strap is only meaningful while the port is unused
         nxt_bank.twos = ~bank_ff.port_used & bank_ff.fmt_s2;

         if (sample_value_in > adc_cfg_pkg::SAMPLE_POS_FS) begin
            code   = adc_cfg_pkg::OB_MAX;
            beyond = 1'b1;
         end else if (sample_value_in < adc_cfg_pkg::SAMPLE_NEG_FS) begin
            code   = adc_cfg_pkg::OB_MIN;
            beyond = 1'b1;
         end else begin
            code = sample_value_in[11:0] ^ adc_cfg_pkg::CODE_MSB;
         end
         if (bank_ff.twos) begin
            code = code ^ adc_cfg_pkg::CODE_MSB;
         end
         nxt_bank.data = code;
         nxt_bank.over = beyond & bank_ff.ovr_active[adc_cfg_pkg::OVR_EN_BIT];

         if (bank_ff.pd_s2) begin
            if (bank_ff.pwr_active[adc_cfg_pkg::PM_PIN_ACT]) begin
               nxt_bank.pwr_state = adc_cfg_pkg::PWR_SBY;
            end else begin
               nxt_bank.pwr_state = adc_cfg_pkg::PWR_OFF;
            end
         end else if (bank_ff.pwr_active[2:0] == adc_cfg_pkg::PWR_FULL_DOWN) begin
            nxt_bank.pwr_state = adc_cfg_pkg::PWR_OFF;
         end else if (bank_ff.pwr_active[2:0] == adc_cfg_pkg::PWR_STANDBY) begin
            nxt_bank.pwr_state = adc_cfg_pkg::PWR_SBY;
         end else begin
            nxt_bank.pwr_state = adc_cfg_pkg::PWR_ON;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         bank_ff            <= '0;
         bank_ff.csb_s1     <= 1'b1;
         bank_ff.csb_s2     <= 1'b1;
         bank_ff.port_setup <= adc_cfg_pkg::RST_PORT_SETUP;
         bank_ff.pwr_master <= adc_cfg_pkg::RST_POWER_MODE;
         bank_ff.pwr_active <= adc_cfg_pkg::RST_POWER_MODE;
         bank_ff.ovr_master <= adc_cfg_pkg::RST_OVERRANGE;
         bank_ff.ovr_active <= adc_cfg_pkg::RST_OVERRANGE;
      end else begin
         bank_ff <= nxt_bank;
      end
   end

   assign data_out        = bank_ff.data;
   assign overrange_out   = bank_ff.over;
   assign twos_coding_out = bank_ff.twos;
   assign port_active_out = bank_ff.port_used;
   assign power_state_out = bank_ff.pwr_state;
endmodule : adc_config_register_bank
`default_nettype wire

// File: verif/adc_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_props (
   // clock, reset and pins
   input wire logic clock_in, rst_in, ce_in, serial_clock_format_pin_in,
   input wire logic port_select_low_in, sdio_in, sdio_out, sdio_oe_out, power_down_pin_in,
   // data path and status
   input wire logic signed [13:0] sample_value_in,
   input wire logic [11:0] data_out,
   input wire logic overrange_out, twos_coding_out, port_active_out,
   input wire adc_cfg_pkg::power_state_type power_state_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // coding may switch mid-flight, so only judge words taken under a steady coding
   sequence s_zero;
      ce_in && sample_value_in == 14'sh0000 ##1 $stable(twos_coding_out);
   endsequence
   sequence s_pos;
      ce_in && sample_value_in > adc_cfg_pkg::SAMPLE_POS_FS ##1 $stable(twos_coding_out);
   endsequence
   sequence s_neg;
      ce_in && sample_value_in < adc_cfg_pkg::SAMPLE_NEG_FS ##1 $stable(twos_coding_out);
   endsequence
   a_zero_code: assert property (
      s_zero |-> data_out == (twos_coding_out ? 12'h000 : 12'h800)) else $error("zero code");
   a_pos_clip: assert property (
      s_pos |-> data_out == (twos_coding_out ? 12'h7ff : 12'hfff)) else $error("pos clip");
   a_neg_clip: assert property (
      s_neg |-> data_out == (twos_coding_out ? 12'h800 : 12'h000)) else $error("neg clip");
   a_in_range: assert property (
      ce_in && sample_value_in <= adc_cfg_pkg::SAMPLE_POS_FS
      && sample_value_in >= adc_cfg_pkg::SAMPLE_NEG_FS |=> !overrange_out)
      else $error("flag in range");
   a_ce_freeze: assert property (
      !ce_in |=> $stable(data_out) && $stable(overrange_out)) else $error("not frozen");
   a_port_coding: assert property (
      port_active_out [*3] |-> !twos_coding_out) else $error("twos in port mode");
   a_strap_level: assert property (
      (!port_active_out && port_select_low_in && $stable(serial_clock_format_pin_in)) [*6]
      |-> twos_coding_out == serial_clock_format_pin_in) else $error("strap level");
   a_idle_port: assert property (
      (port_select_low_in && !port_active_out) [*4] |=> !port_active_out)
      else $error("port woke");
   a_sel_quiet: assert property (
      port_select_low_in [*3] |-> !sdio_oe_out) else $error("drives when idle");
   a_pin_power: assert property (
      power_down_pin_in [*5] |-> power_state_out != adc_cfg_pkg::PWR_ON)
      else $error("pin ignored");
endmodule : adc_cfg_props
bind adc_config_register_bank adc_cfg_props props_u (.clock_in(clock_in), .rst_in(rst_in),
   .ce_in(ce_in), .serial_clock_format_pin_in(serial_clock_format_pin_in),
   .port_select_low_in(port_select_low_in), .sdio_in(sdio_in), .sdio_out(sdio_out),
   .sdio_oe_out(sdio_oe_out), .power_down_pin_in(power_down_pin_in),
   .sample_value_in(sample_value_in), .data_out(data_out), .overrange_out(overrange_out),
   .twos_coding_out(twos_coding_out), .port_active_out(port_active_out),
   .power_state_out(power_state_out));
`default_nettype wire

// File: verif/serial_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_ctl_model (
   // link pins
   output var logic       sclk_out,
   output var logic       sel_low_out,
   output var logic       mosi_out,
   input  wire logic      line_in,
   // readback
   output var logic       rd_valid_out,
   output var logic [7:0] rd_byte_out
);
   initial begin
      sclk_out = 1'b0;
      sel_low_out = 1'b1;
      mosi_out = 1'b0;
      rd_valid_out = 1'b0;
      rd_byte_out = 8'h00;
   end
   // clock stands low between frames
   task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdat,
                        input logic lsb);
      logic [23:0] w;
      w = {rd, 2'b00, addr, wdat};
      // lsb-first: instruction word and data byte each go out reversed
      if (lsb) begin
         w[23:8] = {<<{w[23:8]}};
         w[7:0]  = {<<{w[7:0]}};
      end
      #3.3 sel_low_out = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         // released line: toggle so a stale value never reads back
         mosi_out = (rd && i < 8) ? ~mosi_out : w[i];
         #7.5 sclk_out = 1'b1;
         if (rd && i < 8) rd_byte_out[i] = line_in;
         #7.5 sclk_out = 1'b0;
      end
      if (rd && lsb) rd_byte_out = {<<{rd_byte_out}};
      #7.5 sel_low_out = 1'b1;
      rd_valid_out = rd;
      #7.5 rd_valid_out = 1'b0;
   endtask : frame
endmodule : serial_ctl_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] ID = 8'h5c; // arbitrary value
   localparam logic [1:0] GR = 2'b01;
   logic clock_in = 0, rst_in = 1, ce_in = 0, strap_mode = 1, strap_lvl = 0, power_down_pin_action = 0;
   logic sclk, sel_low, mosi, rd_valid, sdio_o, sdio_oe, ovr, twos, pact, pend = 0;
   logic exp_twos = 0, ovr_en = 1, lsb_mode = 0;
   logic signed [13:0] smp = 0;
   logic [7:0] rd_byte;
   logic [11:0] dat;
   logic [1:0] prev;
   adc_cfg_pkg::power_state_type pst;
   wire logic pin = strap_mode ? strap_lvl : sclk;
   wire logic line = sdio_oe ? sdio_o : mosi;
   logic [7:0] rd_q[$];
   logic [12:0] d_q[$];
   int bad_count = 0, compares = 0, cyc = 0;
   logic [12:0] ra[7] = '{13'h000, 13'h001, 13'h002, 13'h008, 13'h02a, 13'h0ff, 13'h005};
   logic [7:0] re[7] = '{8'h18, ID, {3'b000, GR, 3'b000}, 8'h00, 8'h01, 8'h00, 8'h00};
   // mode byte, pin level, expected power state
   logic [10:0] pt[6] = '{{8'h02, 3'b010}, {8'h01, 3'b001}, {8'h03, 3'b000},
                          {8'h00, 3'b101}, {8'h20, 3'b110}, {8'h04, 3'b000}};
   always #10 clock_in = ~clock_in;
   adc_config_register_bank #(.PART_ID(ID), .GRADE(GR)) dut_u (.clock_in(clock_in),
      .rst_in(rst_in), .ce_in(ce_in), .serial_clock_format_pin_in(pin),
      .port_select_low_in(sel_low), .sdio_in(line), .sdio_out(sdio_o), .sdio_oe_out(sdio_oe),
      .power_down_pin_in(power_down_pin_action), .sample_value_in(smp), .data_out(dat), .overrange_out(ovr),
      .twos_coding_out(twos), .port_active_out(pact), .power_state_out(pst));
   serial_ctl_model model_u (.sclk_out(sclk), .sel_low_out(sel_low), .mosi_out(mosi),
      .line_in(line), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));
   task automatic bad(input logic [15:0] e, g);
      bad_count++;
      $display("BAD %0t exp %h got %h", $time, e, g);
   endtask : bad
   task automatic chk_byte(input logic [7:0] e, g);
      compares++;
      if (g !== e) bad(16'(e), 16'(g));
   endtask : chk_byte
   task automatic chk_word(input logic [12:0] e, g);
      compares++;
      if (g !== e) bad(16'(e), 16'(g));
   endtask : chk_word
   task automatic chk_stat(input logic [3:0] e, g);
      compares++;
      if (g !== e) bad(16'(e), 16'(g));
   endtask : chk_stat
   function automatic logic [12:0] expw(input logic signed [13:0] s);
      logic signed [13:0] c;
      c = s > 14'sd2047 ? 14'sd2047 : (s < -14'sd2048 ? -14'sd2048 : s);
      return {(c != s) & ovr_en, c[11:0] ^ (exp_twos ? 12'h000 : 12'h800)};
   endfunction : expw
   task automatic put(input logic signed [13:0] s);
      @(posedge clock_in) #1 smp = s;
      pend = 1;
      d_q.push_back(expw(s));
   endtask : put
   task automatic idle();
      @(posedge clock_in) #1 pend = 0;
      repeat (3) @(posedge clock_in);
   endtask : idle
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      model_u.frame(1'b0, a, d, lsb_mode);
      repeat (10) @(posedge clock_in);
   endtask : wr
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      model_u.frame(1'b1, a, 8'h00, lsb_mode);
      repeat (10) @(posedge clock_in);
   endtask : rd
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // results arrive in issue order, so the oldest note is always the match
   always @(posedge rd_valid) chk_byte(rd_q.pop_front(), rd_byte);
   always @(posedge clock_in) if (pend) begin
      #2 chk_word(d_q.pop_front(), {ovr, dat});
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'hbeab180f));
      repeat (6) @(posedge clock_in);
      #1 rst_in = 0;
      ce_in = 1;
      for (int k = 1; k >= 0; k--) begin
         @(posedge clock_in) #1 strap_lvl = k[0];
         exp_twos = k[0];
         repeat (8) @(posedge clock_in);
         chk_stat({exp_twos, 3'b000}, {twos, pact, pst});
         foreach (ra[i]) put(14'sd3000 - 14'(i * 1000));
         repeat (4) put(14'($urandom_range(4095)) - 14'sh0800);
         idle();
      end
      $display("test strap done");
      @(posedge clock_in) #1 strap_mode = 0;
      foreach (ra[i]) rd(ra[i], re[i]);
      chk_stat(4'b0100, {twos, pact, pst});
      wr(13'h001, 8'hff);
      wr(13'h005, 8'h00);
      rd(13'h001, ID);
      $display("test readback done");
      prev = 2'b00;
      foreach (pt[i]) begin
         wr(13'h008, pt[i][10:3]);
         chk_stat({2'b01, prev}, {twos, pact, pst});
         wr(13'h0ff, 8'h01);
         @(posedge clock_in) #1 power_down_pin_action = pt[i][2];
         repeat (8) @(posedge clock_in);
         chk_stat({2'b01, pt[i][1:0]}, {twos, pact, pst});
         prev = pt[i][1:0];
      end
      rd(13'h0ff, 8'h00);
      $display("test power done");
      wr(13'h02a, 8'h00);
      put(14'sd3000);
      idle();
      wr(13'h0ff, 8'h01);
      ovr_en = 0;
      put(-14'sd3000);
      idle();
      wr(13'h000, 8'h42);
      lsb_mode = 1;
      rd(13'h000, 8'h5a);
      rd(13'h001, ID);
      wr(13'h000, 8'h3c);
      lsb_mode = 0;
      ovr_en = 1;
      put(14'sd3000);
      idle();
      rd(13'h02a, 8'h01);
      rd(13'h008, 8'h00);
      @(posedge clock_in) #1 ce_in = 0;
      repeat (3) @(posedge clock_in);
      #1 ce_in = 1;
      $display("test overrange done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
